// File: rtl/rsc_strap_capture.sv
// Strap pin capture at reset release with two read-only status registers
// Notes on behaviour
// - capture at reset release, hold until reset
// - soft register bit 7 shows select pin
// - soft select: bits 6:4 code pins 3,2
// - hard select: bits 7:2 pins 5 to 0
// - hard field zero when soft selected
//
// Local design decision: the strobed register port.
module rsc_strap_capture
#(
  parameter int SETTLE_CYC = rsc_pkg::PULL_SETTLE_CYC
)
(
  input wire logic mclk, // 250 MHz clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic hard_soft_select_pin, // Strap mode select pin level
  input wire logic [5:0] strap_pin, // Strap pin levels 5 to 0
  input wire logic [7:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Write data, registers are read-only
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [7:0] reg_rdata, // Read data, cycle after read strobe
  output logic strap_pull_up, // Pull on strap pin 2: 1 up, 0 down
  output logic capture_done // Capture complete, registers valid
);
  rsc_pkg::rsc_state_t state_r;
  rsc_pkg::rsc_state_t state_nxt;
  logic [rsc_pkg::SETTLE_CNT_W-1:0] settle_r;
  logic [rsc_pkg::SETTLE_CNT_W-1:0] settle_nxt;
  logic strap_mode_flag_r;
  logic strap_mode_flag_nxt;
  logic pin3_r;
  logic pin3_nxt;
  logic pin2_pd_r;
  logic pin2_pd_nxt;
  logic [2:0] soft_strap_code_r;
  logic [2:0] soft_strap_code_nxt;
  logic [5:0] hard_strap_code_r;
  logic [5:0] hard_strap_code_nxt;
  logic pull_up_r;
  logic pull_up_nxt;
  logic done_r;
  logic done_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [2:0] soft_code_dec;
  logic [7:0] soft_reg_val;
  logic [7:0] hard_reg_val;

  localparam logic [rsc_pkg::SETTLE_CNT_W-1:0] SETTLE_LAST =
    rsc_pkg::SETTLE_CNT_W'(SETTLE_CYC - 1);

  rsc_tri_decode u_tri_decode
  (
    .pin_hi_lvl(pin3_r),
    .pin_pd_lvl(pin2_pd_r),
    .pin_pu_lvl(strap_pin[2]),
    .soft_code(soft_code_dec)
  );

  // Capture sequence: pins under pull-down at release, then in soft mode pin 2 under pull-up
  always_comb
  begin
    state_nxt = state_r;
    settle_nxt = settle_r;
    strap_mode_flag_nxt = strap_mode_flag_r;
    pin3_nxt = pin3_r;
    pin2_pd_nxt = pin2_pd_r;
    soft_strap_code_nxt = soft_strap_code_r;
    hard_strap_code_nxt = hard_strap_code_r;
    pull_up_nxt = pull_up_r;
    done_nxt = done_r;
    unique case (state_r)
      rsc_pkg::RSC_PROBE_LOW:
      begin
        // latch at first edge after release
        strap_mode_flag_nxt = hard_soft_select_pin;
        pin3_nxt = strap_pin[3];
        pin2_pd_nxt = strap_pin[2];
        hard_strap_code_nxt = hard_soft_select_pin ? strap_pin : 6'h00;
        if (hard_soft_select_pin)
        begin
          done_nxt = 1'b1;
          state_nxt = rsc_pkg::RSC_DONE;
        end
        else
        begin
          pull_up_nxt = 1'b1;
          settle_nxt = '0;
          state_nxt = rsc_pkg::RSC_PROBE_HIGH;
        end
      end
      rsc_pkg::RSC_PROBE_HIGH:
      begin
        if (settle_r == SETTLE_LAST)
        begin
          soft_strap_code_nxt = soft_code_dec;
          pull_up_nxt = 1'b0;
          done_nxt = 1'b1;
          state_nxt = rsc_pkg::RSC_DONE;
        end
        else
        begin
          settle_nxt = settle_r + 1'b1;
        end
      end
      rsc_pkg::RSC_DONE:
      begin
        state_nxt = rsc_pkg::RSC_DONE;
      end
      // Unused state code restarts the capture
      default:
      begin
        state_nxt = rsc_pkg::RSC_PROBE_LOW;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_r <= rsc_pkg::RSC_PROBE_LOW;
      settle_r <= '0;
      strap_mode_flag_r <= 1'b0;
      pin3_r <= 1'b0;
      pin2_pd_r <= 1'b0;
      soft_strap_code_r <= 3'h0;
      hard_strap_code_r <= 6'h00;
      pull_up_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      settle_r <= settle_nxt;
      strap_mode_flag_r <= strap_mode_flag_nxt;
      pin3_r <= pin3_nxt;
      pin2_pd_r <= pin2_pd_nxt;
      soft_strap_code_r <= soft_strap_code_nxt;
      hard_strap_code_r <= hard_strap_code_nxt;
      pull_up_r <= pull_up_nxt;
      done_r <= done_nxt;
    end
  end

  // Register images
  always_comb
  begin
    soft_reg_val = rsc_pkg::SOFT_STRAP_CAPTURE_RST;
    hard_reg_val = rsc_pkg::HARD_STRAP_CAPTURE_RST;
    soft_reg_val[rsc_pkg::MODE_FLAG_BIT] = strap_mode_flag_r;
    // soft field zero in hard mode
    soft_reg_val[rsc_pkg::SOFT_CODE_LSB +: rsc_pkg::SOFT_CODE_W] =
      strap_mode_flag_r ? 3'h0 : soft_strap_code_r;
    // hard field zero in soft mode
    hard_reg_val[rsc_pkg::HARD_CODE_LSB +: rsc_pkg::HARD_CODE_W] =
      strap_mode_flag_r ? hard_strap_code_r : 6'h00;
  end

  // Read port; writes are accepted and ignored, unmapped reads give zero
  always_comb
  begin
    rdata_nxt = 8'h00;
    if (reg_rd)
    begin
      unique case (reg_addr)
        rsc_pkg::SOFT_STRAP_CAPTURE_OFS: rdata_nxt = soft_reg_val;
        rsc_pkg::HARD_STRAP_CAPTURE_OFS: rdata_nxt = hard_reg_val;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      rdata_r <= 8'h00;
    else
      rdata_r <= rdata_nxt;
  end

  assign reg_rdata = rdata_r;
  assign strap_pull_up = pull_up_r;
  assign capture_done = done_r;
endmodule

// File: rtl/rsc_pkg.sv
// Register map, field layout and timing constants of the strap capture block
package rsc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [ADDR_W-1:0] SOFT_STRAP_CAPTURE_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] HARD_STRAP_CAPTURE_OFS = 8'h09;

  // Reset values
  localparam logic [DATA_W-1:0] SOFT_STRAP_CAPTURE_RST = 8'h00;
  localparam logic [DATA_W-1:0] HARD_STRAP_CAPTURE_RST = 8'h00;

  // Field positions
  localparam int MODE_FLAG_BIT = 7;
  localparam int SOFT_CODE_LSB = 4;
  localparam int SOFT_CODE_W = 3;
  localparam int HARD_CODE_LSB = 2;
  localparam int HARD_CODE_W = 6;

  // Soft code levels of the tri-level pin
  localparam logic [1:0] TRI_LOW = 2'h0;
  localparam logic [1:0] TRI_FLOAT = 2'h1;
  localparam logic [1:0] TRI_HIGH = 2'h2;
  localparam logic [2:0] TRI_COUNT = 3'h3;

  // Timing: clock period and settling time of the pull-up probe
  localparam int CLK_PERIOD_PS = 4000;
  localparam int PULL_SETTLE_NS = 40;
  localparam int PULL_SETTLE_CYC =
    (PULL_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SETTLE_CNT_W = 8;

  typedef enum logic [1:0]
  {
    RSC_PROBE_LOW,
    RSC_PROBE_HIGH,
    RSC_DONE
  } rsc_state_t;
endpackage

// File: rtl/rsc_tri_decode.sv
// Soft strap code from one two-level pin and one tri-level pin
module rsc_tri_decode
(
  input wire logic pin_hi_lvl, // Level of strap pin 3
  input wire logic pin_pd_lvl, // Strap pin 2 seen with pull-down
  input wire logic pin_pu_lvl, // Strap pin 2 seen with pull-up
  output logic [2:0] soft_code // Combined code 0 to 5
);
  logic [1:0] tri_lvl;

  always_comb
  begin
    if (pin_pd_lvl && pin_pu_lvl)
      tri_lvl = rsc_pkg::TRI_HIGH;
    else if (!pin_pd_lvl && !pin_pu_lvl)
      tri_lvl = rsc_pkg::TRI_LOW;
    else
      tri_lvl = rsc_pkg::TRI_FLOAT;
  end

  always_comb
  begin
    soft_code = (pin_hi_lvl ? rsc_pkg::TRI_COUNT : 3'h0) + {1'b0, tri_lvl};
  end
endmodule

// File: testbench/rsc_strap_board.sv
// Board strap model: fixed levels, pin 2 may float and follow the pull
module rsc_strap_board
(
  input wire logic sel, // Select level
  input wire logic flt, // Pin 2 floating
  input wire logic [5:0] lvl, // Driven levels
  input wire logic pull_up, // Pull on pin 2
  output logic hard_soft_select_pin, // Select pin
  output logic [5:0] strap_pin // Strap pins
);
  timeunit 1ns;
  timeprecision 1ps;
  assign hard_soft_select_pin = sel;
  assign strap_pin = {lvl[5:3], flt ? pull_up : lvl[2], lvl[1:0]};
endmodule

// File: testbench/rsc_strap_capture_assertions.sv
// Assertions on the strap capture register port and the done output
module rsc_strap_capture_assertions
(
  input wire logic mclk, // Clock
  input wire logic rst_n, // Reset
  input wire logic hard_soft_select_pin, // Select pin
  input wire logic [5:0] strap_pin, // Strap pins
  input wire logic [7:0] reg_addr, // Address
  input wire logic reg_rd, // Read strobe
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic capture_done // Done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic first_r, sel_r;
  logic [5:0] pins_r;
  always_ff @(posedge mclk)
  begin
    first_r <= !rst_n;
    if (rst_n && first_r)
    begin
      sel_r <= hard_soft_select_pin;
      pins_r <= strap_pin;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence rd_soft;
    $past(reg_rd) && $past(reg_addr) == rsc_pkg::SOFT_STRAP_CAPTURE_OFS;
  endsequence
  sequence rd_hard;
    $past(reg_rd) && $past(reg_addr) == rsc_pkg::HARD_STRAP_CAPTURE_OFS;
  endsequence
  a_done_holds: assert property (capture_done |=> capture_done)
    else $error("done dropped");
  a_mode_bit: assert property (rd_soft |-> reg_rdata[7] == sel_r)
    else $error("mode bit wrong");
  a_soft_code: assert property (rd_soft ##0 (capture_done && !sel_r) |->
    reg_rdata[6:4] <= 3'h5 && (reg_rdata[6:4] >= 3'h3) == pins_r[3])
    else $error("soft code wrong");
  a_hard_field: assert property (rd_hard ##0 sel_r |-> reg_rdata == {pins_r, 2'h0})
    else $error("hard field wrong");
  a_hard_zero: assert property (rd_hard ##0 !sel_r |-> reg_rdata == 8'h00)
    else $error("hard field not zero");
  a_soft_zero: assert property (rd_soft ##0 sel_r |-> reg_rdata[6:0] == 7'h00)
    else $error("soft field not zero");
endmodule
bind rsc_strap_capture rsc_strap_capture_assertions u_chk(.mclk(mclk), .rst_n(rst_n),
  .hard_soft_select_pin(hard_soft_select_pin), .strap_pin(strap_pin),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .capture_done(capture_done));

// File: testbench/rsc_strap_capture_tb.sv
// Testbench: reset under all six soft codes and three hard pin patterns, then read both registers
module rsc_strap_capture_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic sel = 1'b0;
  logic flt = 1'b0;
  logic [5:0] lvl = 6'h00;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata, e_soft, e_hard;
  logic pull_up, done, pin_sel;
  logic [5:0] strap_pin;
  logic [5:0] hv [3] = '{6'h00, 6'h3F, 6'h2D};
  int n_mismatch = 0;
  int n_tests = 0;
  initial forever #2 mclk = ~mclk;
  rsc_strap_board u_rsc_strap_board(.sel(sel), .flt(flt), .lvl(lvl), .pull_up(pull_up),
    .hard_soft_select_pin(pin_sel), .strap_pin(strap_pin));
  rsc_strap_capture #(.SETTLE_CYC(2)) u_rsc_strap_capture(.mclk(mclk), .rst_n(rst_n),
    .hard_soft_select_pin(pin_sel), .strap_pin(strap_pin), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .strap_pull_up(pull_up), .capture_done(done));
  task automatic conclude();
    if (n_mismatch == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  initial
  begin
    for (int i = 0; i < 9; i++)
    begin
      @(posedge mclk);
      rst_n <= 1'b0;
      sel <= (i > 5);
      flt <= (i < 6) && (i % 3 == 1);
      lvl <= (i < 6) ? {2'h3, 1'(i / 3), 1'(i % 3 == 2), 2'h1} : hv[i - 6];
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      e_soft = {sel, (i < 6) ? 3'(i) : 3'h0, 4'h0};
      e_hard = sel ? {lvl, 2'h0} : 8'h00;
      @(posedge mclk);
      #1 chk({7'h00, pull_up}, {7'h00, !sel});
      for (int k = 0; k < 50 && done !== 1'b1; k++) @(posedge mclk);
      #1 chk({7'h00, done}, 8'h01);
      if (done !== 1'b1) break;
      chk({7'h00, pull_up}, 8'h00);
      rd(rsc_pkg::SOFT_STRAP_CAPTURE_OFS, e_soft);
      rd(rsc_pkg::HARD_STRAP_CAPTURE_OFS, e_hard);
      wr(rsc_pkg::HARD_STRAP_CAPTURE_OFS, 8'hFF);
      wr(rsc_pkg::SOFT_STRAP_CAPTURE_OFS, 8'hFF);
      sel <= ~sel;
      lvl <= ~lvl;
      rd(rsc_pkg::HARD_STRAP_CAPTURE_OFS, e_hard);
      rd(rsc_pkg::SOFT_STRAP_CAPTURE_OFS, e_soft);
      rd(8'h0A, 8'h00);
    end
    conclude();
  end
endmodule
